// ==== design/cmbi_clkgen.sv ====
// bus clock source: divider when generated, edge detect when supplied
`timescale 1ns/10ps
module cmbi_clkgen (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // configuration (already synchronised)
    input  wire logic       src_sel,
    input  wire logic [2:0] div_setting,
    input  wire logic       ext_clk,
    // bus clock level and edges
    output logic            bus_clk,
    output logic            bus_rise,
    output logic            bus_fall
);

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       clk_reg;
    logic       clk_next;
    logic       rise_reg;
    logic       rise_next;
    logic       fall_reg;
    logic       fall_next;
    logic [3:0] period;
    logic [3:0] hi_len;

    // high phase takes the odd cycle of an odd divide
    assign period = {1'b0, div_setting} + cmbi_pkg::DIV_OFFSET;
    assign hi_len = period - {1'b0, period[3:1]};

    // divider or external follower
    always_comb begin
        cnt_next  = cnt_reg;
        clk_next  = clk_reg;
        rise_next = 1'b0;
        fall_next = 1'b0;
        if (src_sel) begin
            cnt_next = (cnt_reg >= period - 4'h1) ? 4'h0 : cnt_reg + 4'h1;
            clk_next = (cnt_next < hi_len);
        end else begin
            cnt_next = 4'h0;
            clk_next = ext_clk;
        end
        rise_next = clk_next & ~clk_reg;
        fall_next = ~clk_next & clk_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg  <= 4'h0;
            clk_reg  <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            clk_reg  <= clk_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign bus_clk  = clk_reg;
    assign bus_rise = rise_reg;
    assign bus_fall = fall_reg;

endmodule : cmbi_clkgen

// ==== design/cmbi_pkg.sv ====
// shared constants and types for the processor memory-bus interface
package cmbi_pkg;

    // access size codes driven in standard bus mode
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_BYTE = 2'h0;

    // bus clock divider: period is setting plus this offset
    localparam logic [3:0] DIV_OFFSET = 4'h2;

    // restart address after reset release
    localparam logic [31:0] RESTART_ADDR = 32'h0000_0000;

    // core clock and internal reset settle time
    localparam int CLK_PERIOD_NS    = 100;
    localparam int RESET_SETTLE_NS  = 2000;
    localparam int RESET_SETTLE_CYC = (RESET_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RESET_SETTLE_CNT = 8'(RESET_SETTLE_CYC);

    // reset values of the pin synchronisers (active-low inputs idle high)
    localparam logic [13:0] PIN_SYNC_INIT = 14'h0178;
    localparam logic [31:0] DATA_SYNC_INIT = 32'h0000_0000;

    // bus sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ANNOUNCED,
        ST_ACCESS
    } cmbi_state_t;

    // one access as the core requests it
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        write;
        logic [1:0]  size;
        logic [3:0]  byte_en;
        logic        lock;
    } cmbi_req_t;

    // registered output pins of the bus
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  access_size_code;
        logic        write_not_read;
        logic        atomic_sequence;
        logic        memory_request_n;
        logic        sequential_access;
        logic [31:0] data;
    } cmbi_pins_t;

endpackage : cmbi_pkg

// ==== design/cmbi_sync.sv ====
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module cmbi_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // asynchronous and synchronised levels
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      dout
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg;

endmodule : cmbi_sync

// ==== design/cmbi_top.sv ====
// processor memory-bus interface: pins, bus clock, interrupts and reset
`timescale 1ns/10ps
module cmbi_top (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // core access request and answer
    input  wire logic              req_valid,
    input  wire cmbi_pkg::cmbi_req_t req,
    output logic                   req_ready,
    output logic                   access_done,
    output logic [31:0]            rdata,
    // core interrupt side
    input  wire logic              fast_interrupt_enable,
    input  wire logic              normal_interrupt_enable,
    output logic                   fast_interrupt_take,
    output logic                   normal_interrupt_take,
    // coprocessor write controlling the inverted clock
    input  wire logic              coprocessor_write_instruction,
    input  wire logic              cp_inv_clock_enable,
    // core reset side
    output logic                   core_in_reset,
    output logic                   restart_pulse,
    output logic [31:0]            restart_addr,
    // static configuration pins and pll lock
    input  wire logic              clock_source_select,
    input  wire logic [2:0]        bus_clock_divider_setting,
    input  wire logic              enhanced_mode,
    input  wire logic              pll_stable,
    // enable and sleep pins
    input  wire logic              data_bus_output_enable,
    input  wire logic              request_outputs_enable,
    input  wire logic              io_sleep_n,
    // interrupt and wait pins
    input  wire logic              fast_interrupt_request_n,
    input  wire logic              normal_interrupt_request_n,
    input  wire logic              wait_extend_n,
    // bus clock pin
    input  wire logic              bus_clock_in,
    output logic                   bus_clock_out,
    output logic                   bus_clock_oe,
    output logic                   inverted_bus_clock,
    // bus outputs
    output logic [31:0]            addr_out,
    output logic [1:0]             access_size_code,
    output logic                   write_not_read,
    output logic                   atomic_sequence,
    output logic                   memory_request_n,
    output logic                   sequential_access,
    output logic                   request_oe,
    // data bus pin
    input  wire logic [31:0]       data_in,
    output logic [31:0]            data_out,
    output logic                   data_oe,
    // reset done
    output logic                   reset_done_n
);

    // synchronised pins
    logic [13:0] pins_s;
    logic [31:0] data_s;
    logic        src_s;
    logic [2:0]  div_s;
    logic        enh_s;
    logic        dbe_s;
    logic        mse_s;
    logic        sleep_n_s;
    logic        fiq_n_s;
    logic        irq_n_s;
    logic        wait_n_s;
    logic        mclk_s;
    logic        pll_s;
    logic        bus_clk;
    logic        bus_rise;
    logic        bus_fall;

    cmbi_sync #(.W(14), .INIT(cmbi_pkg::PIN_SYNC_INIT)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({clock_source_select, bus_clock_divider_setting, enhanced_mode,
                 data_bus_output_enable, request_outputs_enable, io_sleep_n,
                 fast_interrupt_request_n, normal_interrupt_request_n, wait_extend_n,
                 bus_clock_in, pll_stable, 1'b0}),
        .dout  (pins_s)
    );

    // read data is only looked at on a bus rise, long after it settled
    cmbi_sync #(.W(32), .INIT(cmbi_pkg::DATA_SYNC_INIT)) u_data_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (data_in),
        .dout  (data_s)
    );

    assign src_s     = pins_s[13];
    assign div_s     = pins_s[12:10];
    assign enh_s     = pins_s[9];
    assign dbe_s     = pins_s[8];
    assign mse_s     = pins_s[7];
    assign sleep_n_s = pins_s[6];
    assign fiq_n_s   = pins_s[5];
    assign irq_n_s   = pins_s[4];
    assign wait_n_s  = pins_s[3];
    assign mclk_s    = pins_s[2];
    assign pll_s     = pins_s[1];

    cmbi_clkgen u_clkgen (
        .clk         (clk),
        .rst_n       (rst_n),
        .src_sel     (src_s),
        .div_setting (div_s),
        .ext_clk     (mclk_s),
        .bus_clk     (bus_clk),
        .bus_rise    (bus_rise),
        .bus_fall    (bus_fall)
    );

    // size pins: code in standard mode, active-low mask in enhanced mode
    function automatic logic [1:0] size_pins(input logic enh, input cmbi_pkg::cmbi_req_t r);
        size_pins = enh ? ~r.byte_en[1:0] : r.size;
    endfunction : size_pins

    function automatic logic [31:0] addr_pins(input logic enh, input cmbi_pkg::cmbi_req_t r);
        addr_pins = enh ? {r.addr[31:2], ~r.byte_en[3:2]} : r.addr;
    endfunction : addr_pins

    // sequencer and bus pin state
    cmbi_pkg::cmbi_state_t state_reg;
    cmbi_pkg::cmbi_state_t state_next;
    cmbi_pkg::cmbi_req_t   cur_reg;
    cmbi_pkg::cmbi_req_t   cur_next;
    cmbi_pkg::cmbi_pins_t  bus_reg;
    cmbi_pkg::cmbi_pins_t  bus_next;
    cmbi_pkg::cmbi_pins_t  pins_reg;
    cmbi_pkg::cmbi_pins_t  pins_next;
    logic        wphase_reg;
    logic        wphase_next;
    logic        doe_reg;
    logic        doe_next;
    logic        roe_reg;
    logic        roe_next;
    logic        done_reg;
    logic        done_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        take;

    // accept only at a bus fall while idle and out of reset
    assign take      = bus_fall & (state_reg == cmbi_pkg::ST_IDLE) & req_valid;
    assign req_ready = bus_fall & (state_reg == cmbi_pkg::ST_IDLE);

    // bus sequencer: announce on fall, address on rise, finish on rise
    always_comb begin
        state_next  = state_reg;
        cur_next    = cur_reg;
        bus_next    = bus_reg;
        wphase_next = wphase_reg;
        done_next   = 1'b0;
        rdata_next  = rdata_reg;
        unique case (state_reg)
            cmbi_pkg::ST_IDLE: begin
                if (bus_rise) begin
                    bus_next.atomic_sequence = 1'b0;     // sequence over
                end
                if (take) begin
                    cur_next                   = req;
                    bus_next.memory_request_n  = 1'b0;   // access next cycle
                    bus_next.sequential_access = 1'b1;
                    state_next                 = cmbi_pkg::ST_ANNOUNCED;
                end
            end
            cmbi_pkg::ST_ANNOUNCED: begin
                if (bus_rise) begin
                    // one schedule for address and its companions
                    bus_next.addr             = addr_pins(enh_s, cur_reg);
                    bus_next.access_size_code = size_pins(enh_s, cur_reg);
                    bus_next.write_not_read   = cur_reg.write;
                    bus_next.atomic_sequence  = cur_reg.lock;
                    bus_next.data             = cur_reg.wdata;
                    state_next                = cmbi_pkg::ST_ACCESS;
                end
            end
            cmbi_pkg::ST_ACCESS: begin
                if (bus_fall) begin
                    bus_next.memory_request_n  = 1'b1;
                    bus_next.sequential_access = 1'b0;
                    wphase_next                = cur_reg.write;
                end
                // a low wait at the rise holds the access one more cycle
                if (bus_rise && wait_n_s) begin
                    rdata_next  = cur_reg.write ? rdata_reg : data_s;
                    done_next   = 1'b1;
                    wphase_next = 1'b0;
                    state_next  = cmbi_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // final pin values: sleep overrides the bus pins but not data_oe or request_oe, registered for clean edges
    always_comb begin
        pins_next = bus_reg;
        if (!sleep_n_s) begin
            pins_next                  = '0;
            pins_next.memory_request_n = 1'b1;
        end
        doe_next = wphase_next & dbe_s;
        roe_next = mse_s;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg  <= cmbi_pkg::ST_IDLE;             // idle cycles in reset
            cur_reg    <= '0;
            bus_reg    <= '{memory_request_n: 1'b1, default: '0};
            pins_reg   <= '{memory_request_n: 1'b1, default: '0};
            wphase_reg <= 1'b0;
            doe_reg    <= 1'b0;
            roe_reg    <= 1'b0;
            done_reg   <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            state_reg  <= state_next;
            cur_reg    <= cur_next;
            bus_reg    <= bus_next;
            pins_reg   <= pins_next;
            wphase_reg <= wphase_next;
            doe_reg    <= doe_next;
            roe_reg    <= roe_next;
            done_reg   <= done_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign addr_out          = pins_reg.addr;
    assign access_size_code  = pins_reg.access_size_code;
    assign write_not_read    = pins_reg.write_not_read;
    assign atomic_sequence   = pins_reg.atomic_sequence;
    assign memory_request_n  = pins_reg.memory_request_n;
    assign sequential_access = pins_reg.sequential_access;
    assign data_out          = pins_reg.data;
    assign data_oe           = doe_reg;
    assign request_oe        = roe_reg;
    assign access_done       = done_reg;
    assign rdata             = rdata_reg;

    // bus clock pin and its inverse; the coprocessor can switch the inverse off
    logic inv_en_reg;
    logic inv_en_next;
    logic mclk_oe_reg;
    logic mclk_oe_next;
    logic inv_reg;
    logic inv_next;
    logic bclk_reg;
    logic bclk_next;

    always_comb begin
        inv_en_next  = coprocessor_write_instruction ? cp_inv_clock_enable : inv_en_reg;
        mclk_oe_next = src_s;
        bclk_next    = src_s & bus_clk & sleep_n_s;
        inv_next     = src_s & inv_en_next & ~bus_clk & sleep_n_s;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inv_en_reg  <= 1'b1;
            mclk_oe_reg <= 1'b0;
            inv_reg     <= 1'b0;
            bclk_reg    <= 1'b0;
        end else begin
            inv_en_reg  <= inv_en_next;
            mclk_oe_reg <= mclk_oe_next;
            inv_reg     <= inv_next;
            bclk_reg    <= bclk_next;
        end
    end

    assign bus_clock_out      = bclk_reg;
    assign bus_clock_oe       = mclk_oe_reg;
    assign inverted_bus_clock = inv_reg;

    // interrupts: levels only, a taken fast interrupt masks the normal one
    assign fast_interrupt_take   = fast_interrupt_enable & ~fiq_n_s;
    assign normal_interrupt_take = normal_interrupt_enable & ~irq_n_s
                                   & ~fast_interrupt_take;

    // reset sequencing towards the core and the reset-done pin
    logic       inrst_reg;
    logic       inrst_next;
    logic       rpulse_reg;
    logic       rpulse_next;
    logic [7:0] settle_reg;
    logic [7:0] settle_next;
    logic       rdone_n_reg;
    logic       rdone_n_next;

    always_comb begin
        inrst_next   = 1'b0;
        rpulse_next  = inrst_reg;
        settle_next  = (settle_reg < cmbi_pkg::RESET_SETTLE_CNT) ? settle_reg + 8'h01
                                                                 : settle_reg;
        // pll lock can be lost later; reset-done follows it back low
        rdone_n_next = (settle_reg >= cmbi_pkg::RESET_SETTLE_CNT) & pll_s;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inrst_reg   <= 1'b1;
            rpulse_reg  <= 1'b0;
            settle_reg  <= 8'h00;
            rdone_n_reg <= 1'b0;
        end else begin
            inrst_reg   <= inrst_next;
            rpulse_reg  <= rpulse_next;
            settle_reg  <= settle_next;
            rdone_n_reg <= rdone_n_next;
        end
    end

    assign core_in_reset = inrst_reg;
    assign restart_pulse = rpulse_reg;
    assign restart_addr  = cmbi_pkg::RESTART_ADDR;
    assign reset_done_n  = rdone_n_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_dbe_float;
        !dbe_s |=> !data_oe;
    endproperty
    a_dbe_float: assert property (p_dbe_float) else $error("data driven while disabled");

    property p_drive_write;
        data_oe |-> write_not_read || !sleep_n_s;
    endproperty
    a_drive_write: assert property (p_drive_write) else $error("data driven on read");

    property p_lock_hold;
        (state_reg == cmbi_pkg::ST_ACCESS && cur_reg.lock && sleep_n_s && bus_reg.atomic_sequence)
            |=> bus_reg.atomic_sequence;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("atomic flag fell mid access");

    property p_std_size;
        (state_reg == cmbi_pkg::ST_ANNOUNCED && bus_rise && !enh_s)
            |=> bus_reg.access_size_code == cur_reg.size;
    endproperty
    a_std_size: assert property (p_std_size) else $error("size code mismatch");

    property p_enh_mask;
        (state_reg == cmbi_pkg::ST_ANNOUNCED && bus_rise && enh_s)
            |=> bus_reg.access_size_code == ~cur_reg.byte_en[1:0];
    endproperty
    a_enh_mask: assert property (p_enh_mask) else $error("mask pins mismatch");

    property p_clk_dir;
        ##1 bus_clock_oe == $past(src_s);
    endproperty
    a_clk_dir: assert property (p_clk_dir) else $error("bus clock direction wrong");

    property p_inv_low;
        !src_s |=> !inverted_bus_clock;
    endproperty
    a_inv_low: assert property (p_inv_low) else $error("inverted clock not low");

    property p_req_float;
        !mse_s |=> !request_oe;
    endproperty
    a_req_float: assert property (p_req_float) else $error("request outputs not floated");

    property p_sleep;
        !sleep_n_s |=> memory_request_n && !write_not_read && !atomic_sequence && addr_out == '0;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep levels wrong");

    property p_rdone;
        $rose(reset_done_n) |-> settle_reg >= cmbi_pkg::RESET_SETTLE_CNT && $past(pll_s);
    endproperty
    a_rdone: assert property (p_rdone) else $error("reset done too early");

    property p_wait;
        (state_reg == cmbi_pkg::ST_ACCESS && bus_rise && !wait_n_s) |=> !access_done;
    endproperty
    a_wait: assert property (p_wait) else $error("wait ignored");

    property p_fiq_prio;
        fast_interrupt_take |-> !normal_interrupt_take;
    endproperty
    a_fiq_prio: assert property (p_fiq_prio) else $error("normal over fast");

    c_write: cover property (access_done && write_not_read);
    c_read:  cover property (access_done && !write_not_read);
    c_wait:  cover property (state_reg == cmbi_pkg::ST_ACCESS && bus_rise && !wait_n_s);
    c_lock:  cover property (atomic_sequence && take);

endmodule : cmbi_top

// ==== test/cmbi_bench.sv ====
// self-checking bench for the memory-bus interface
`timescale 1ns/10ps
module cmbi_bench;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, slow = 1'b0, seen, mq, bad = 1'b0;
    logic src = 1'b1, enh = 1'b0, pll = 1'b1, ext_clk = 1'b0;
    logic [3:0]  be = 4'hf;
    cmbi_pkg::cmbi_req_t req = '0;
    logic fast_interrupt_enable = 1'b1, coprocessor_write_instruction = 1'b0;
    logic cp_inv_clock_enable = 1'b1, data_bus_output_enable = 1'b1;
    logic request_outputs_enable = 1'b1, io_sleep_n = 1'b1;
    logic fast_interrupt_request_n = 1'b1, normal_interrupt_request_n = 1'b1;
    logic req_ready, access_done, fast_interrupt_take, normal_interrupt_take;
    logic core_in_reset, restart_pulse, bus_clock_out, bus_clock_oe, bus_clock_in;
    logic inverted_bus_clock, write_not_read, atomic_sequence, memory_request_n;
    logic sequential_access, request_oe, data_oe, reset_done_n, wait_extend_n;
    logic [31:0] rdata, restart_addr, addr_out, data_out, data_in;
    logic [1:0]  access_size_code;
    int          err_total = 0, checks_done = 0, n, cf, cs;
    always #50 clk = ~clk;
    // supplied bus clock runs free, eight core cycles
    always #400 ext_clk = ~ext_clk;
    // pin follows the device while it drives, else the supplied clock
    assign bus_clock_in = src ? bus_clock_out : ext_clk;
    cmbi_top cmbi_top_i (.clk, .rst_n, .req_valid, .req, .req_ready, .access_done,
        .rdata, .fast_interrupt_enable, .normal_interrupt_enable(1'b1),
        .fast_interrupt_take, .normal_interrupt_take, .coprocessor_write_instruction,
        .cp_inv_clock_enable, .core_in_reset, .restart_pulse, .restart_addr,
        .clock_source_select(src), .bus_clock_divider_setting(3'h4),
        .enhanced_mode(enh), .pll_stable(pll), .data_bus_output_enable,
        .request_outputs_enable, .io_sleep_n, .fast_interrupt_request_n,
        .normal_interrupt_request_n, .wait_extend_n, .bus_clock_in, .bus_clock_out,
        .bus_clock_oe, .inverted_bus_clock, .addr_out, .access_size_code,
        .write_not_read, .atomic_sequence, .memory_request_n, .sequential_access,
        .request_oe, .data_in, .data_out, .data_oe, .reset_done_n);
    cmbi_mem cmbi_mem_i (.clk, .slow, .memory_request_n, .addr_out, .data_out,
        .data_oe, .data_in, .wait_extend_n);
    task automatic results;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    // bounded wait at falling edges; running out ends the run
    task automatic till(ref logic s, input logic v);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            seen |= data_oe;
            mq |= !memory_request_n;
            bad |= sequential_access === memory_request_n;
        end while (s !== v && n < 400);
        if (n == 400) begin
            err_total++;
            results();
        end
    endtask : till
    task automatic acc(input logic w, input logic [1:0] sz, input logic lk,
                       input logic sl, output int cyc);
        logic [31:0] ea;
        logic [1:0]  es;
        logic [1:0]  eh;
        @(posedge clk);
        req <= '{32'h0000_1234, 32'h9e37_0000, w, sz, be, lk};
        slow <= sl;
        req_valid <= 1'b1;
        till(req_ready, 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        seen = 1'b0;
        mq = 1'b0;
        till(access_done, 1'b1);
        cyc = n;
        // enhanced mode turns low address bits and size pins into a low-true mask
        eh = enh ? ~be[3:2] : 2'h0;
        es = enh ? ~be[1:0] : sz;
        ea = {30'h048d, eh};
        chk("wnr", w, write_not_read);
        chk("addr", ea, addr_out);
        chk("size", es, access_size_code);
        chk("lock", lk, atomic_sequence);
        chk("mreq", 1, mq);
        chk("data_oe", w & data_bus_output_enable, seen);
        if (w)
            chk("wdata", 32'h9e37_0000, data_out);
        else
            chk("rdata", ea ^ 32'hc3c3_a5a5, rdata);
    endtask : acc
    task automatic t_pins;
        @(posedge clk);
        io_sleep_n <= 1'b0;
        request_outputs_enable <= 1'b0;
        fast_interrupt_request_n <= 1'b0;
        normal_interrupt_request_n <= 1'b0; // held low for the rest of the run
        repeat (6) @(negedge clk);
        chk("sleep_mreq", 1, memory_request_n);
        chk("sleep_wnr", 0, write_not_read);
        chk("sleep_clk", 0, bus_clock_out);
        chk("req_oe", 0, request_oe);
        chk("fiq", 1, fast_interrupt_take);
        chk("irq", 0, normal_interrupt_take);
        @(posedge clk);
        fast_interrupt_enable <= 1'b0;
        io_sleep_n <= 1'b1;
        request_outputs_enable <= 1'b1;
        repeat (6) @(negedge clk);
        chk("irq", 1, normal_interrupt_take);
        chk("req_oe", 1, request_oe);
        seen = 1'b0;
        repeat (12) begin
            @(negedge clk);
            seen |= inverted_bus_clock === bus_clock_out;
        end
        chk("inv_eq", 0, seen);
        @(posedge clk);
        {coprocessor_write_instruction, cp_inv_clock_enable} <= 2'h2;
        @(posedge clk) coprocessor_write_instruction <= 1'b0;
        seen = 1'b0;
        repeat (12) begin
            @(negedge clk);
            seen |= inverted_bus_clock;
        end
        chk("inv_off", 0, seen);
    endtask : t_pins
    // reset held twenty core cycles, beyond two bus clock cycles
    initial begin
        repeat (20) @(negedge clk);
        chk("mreq_rst", 1, memory_request_n);
        chk("busy_rst", 1, core_in_reset);
        chk("done_rst", 0, reset_done_n);
        @(posedge clk) rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk("restart_pulse", 1, restart_pulse);
        till(reset_done_n, 1'b1);
        chk("restart", 32'h0000_0000, restart_addr);
        chk("clk_oe", 1, bus_clock_oe);
        till(bus_clock_out, 1'b0);
        till(bus_clock_out, 1'b1);
        till(bus_clock_out, 1'b0);
        cf = n;
        till(bus_clock_out, 1'b1);
        chk("period", 3'h4 + 2, cf + n);
        acc(1'b1, 2'h2, 1'b1, 1'b0, cf);
        acc(1'b0, 2'h1, 1'b1, 1'b0, cf);
        acc(1'b0, 2'h0, 1'b0, 1'b0, cf);
        acc(1'b0, 2'h2, 1'b0, 1'b1, cs);
        chk("stretch", 1, 32'(cs > cf));
        @(posedge clk) data_bus_output_enable <= 1'b0;
        repeat (4) @(posedge clk);
        acc(1'b1, 2'h2, 1'b0, 1'b0, cf);
        t_pins();
        // losing pll lock pulls reset-done back low
        @(posedge clk) pll <= 1'b0;
        repeat (6) @(negedge clk);
        chk("rdone_pll", 0, reset_done_n);
        // second reset: supplied bus clock and enhanced mode, both static pins
        @(posedge clk) begin
            rst_n <= 1'b0;
            pll <= 1'b1;
            src <= 1'b0;
            enh <= 1'b1;
            be <= 4'h6;
        end
        repeat (20) @(negedge clk);
        chk("done_rst2", 0, reset_done_n);
        @(posedge clk) rst_n <= 1'b1;
        till(reset_done_n, 1'b1);
        chk("clk_oe_in", 0, bus_clock_oe);
        seen = 1'b0;
        repeat (12) begin
            @(negedge clk);
            seen |= inverted_bus_clock;
        end
        chk("inv_in", 0, seen);
        acc(1'b0, 2'h0, 1'b0, 1'b0, cf);
        acc(1'b1, 2'h2, 1'b1, 1'b0, cf);
        chk("seq_inv", 0, bad);
        results();
    end
endmodule : cmbi_bench

// ==== test/cmbi_mem.sv ====
// memory model on the far side of the bus pins
`timescale 1ns/10ps
module cmbi_mem (
    // clock and stall control
    input  wire logic        clk,
    input  wire logic        slow,
    // bus pins
    input  wire logic        memory_request_n,
    input  wire logic [31:0] addr_out,
    input  wire logic [31:0] data_out,
    input  wire logic        data_oe,
    output logic [31:0]      data_in,
    output logic             wait_extend_n
);
    logic [3:0] hold_reg = 4'h0;
    // wire level: device data while it drives, else an address pattern
    assign data_in = data_oe ? data_out : addr_out ^ 32'hc3c3_a5a5;
    // a slow memory pulls wait low for a while after each request
    always_ff @(posedge clk) begin
        hold_reg <= !memory_request_n ? 4'hc : hold_reg - 4'(hold_reg != 4'h0);
        wait_extend_n <= !(slow && hold_reg != 4'h0);
    end
endmodule : cmbi_mem
